// ---- verilog/wcs_top.sv ----
// Weld cycle and alarm sequencer with AXI4-Lite registers.
// Assumes user I/O and analog codes synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module wcs_top #(
  parameter int TICK_CYCLES = wcs_pkg::TICK_CYC,
  parameter int SEEK_MS = wcs_pkg::SEEK_IVL_MS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // AXI4-Lite slave
  input wire logic [wcs_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [wcs_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // User I/O and panel inputs
  input wire logic start_req,
  input wire logic ext_reset_req,
  input wire logic panel_reset,
  input wire logic alarm_in,
  input wire logic overload_in,
  // Analog input codes and measured frequency
  input wire logic [6:0] ext_amp,
  input wire logic ext_amp_ok,
  input wire logic [7:0] ext_offs,
  input wire logic ext_offs_ok,
  input wire logic [15:0] meas_freq,
  // Status and drive outputs
  output logic sonics_on,
  output logic seek_active,
  output logic sys_ready,
  output logic gen_alarm,
  output logic ovl_alarm,
  output logic [6:0] amp_out,
  output logic [7:0] freq_offset,
  output logic irq
);
  import wcs_pkg::*;
  typedef struct packed {
    wcs_state_t st;
    logic start_q;
    logic alarm;
    logic ovl;
    logic [15:0] tick_cnt;
    logic tick;
    logic [7:0] step_cnt;
    logic [7:0] seek_ms;
    logic [15:0] ivl_cnt;
    logic [6:0] amp;
    logic [7:0] offs;
    logic [4:0] ctrl;
    logic [6:0] amp_reg;
    logic [23:0] time_reg;
    logic [7:0] offs_reg;
    logic [15:0] freq;
    logic [2:0] istat;
    logic [2:0] imask;
    logic irq;
    logic sonics;
    logic seek;
    logic rdy;
  } wcs_top_st_t;
  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
  localparam logic [15:0] SEEK_LAST = 16'(SEEK_MS - 1);
  wcs_top_st_t s;
  wcs_top_st_t next_s;
  logic wr_en;
  logic [AXI_AW-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic [AXI_AW-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic start_rise;
  logic fault;
  logic may_start;
  logic [6:0] amp_tgt;
  logic [7:0] offs_sel;
  logic [7:0] ramp_sel;

  wcs_axil u_bus (
    .ref_clk(ref_clk),
    .srst(srst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  // Byte lane mask from write strobes
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign wmask[8*b +: 8] = {8{wr_strb[b]}};
  end

  // Amplitude and offset source selection
  always_comb begin
    amp_tgt = s.amp_reg;
    if (s.ctrl[CTRL_AMPEXT]) begin
      if (ext_amp_ok && ext_amp >= AMP_MIN && ext_amp <= AMP_MAX) begin
        amp_tgt = ext_amp;
      end else begin
        amp_tgt = AMP_FALLBACK;
      end
    end else if (s.amp_reg < AMP_MIN) begin
      amp_tgt = AMP_MIN;
    end else if (s.amp_reg > AMP_MAX) begin
      amp_tgt = AMP_MAX;
    end
    if (s.ctrl[CTRL_OFFEXT]) begin
      offs_sel = ext_offs_ok ? ext_offs : OFFS_ZERO;
    end else begin
      offs_sel = s.offs_reg;
    end
    if (s.st == WCS_SEEK) begin
      ramp_sel = s.time_reg[TM_KRAMP +: 8];
    end else begin
      ramp_sel = s.time_reg[TM_SRAMP +: 8];
    end
  end

  assign start_rise = start_req && !s.start_q;
  assign fault = alarm_in || overload_in;
  assign may_start = start_rise && !fault &&
    !(s.ctrl[CTRL_LATCH] && s.alarm);

  // Register read decode
  always_comb begin
    rd_data = 32'h0;
    rd_err = 1'b0;
    case (rd_addr)
      ADDR_CTRL: rd_data[4:0] = s.ctrl;
      ADDR_AMP: rd_data[6:0] = s.amp_reg;
      ADDR_TIME: rd_data[23:0] = s.time_reg;
      ADDR_OFFS: rd_data[7:0] = s.offs_reg;
      ADDR_STAT: rd_data[4:0] = {s.ovl, s.alarm, s.rdy, s.seek,
        s.sonics};
      ADDR_FREQ: rd_data[15:0] = s.freq;
      ADDR_ISTAT: rd_data[2:0] = s.istat;
      ADDR_IMASK: rd_data[2:0] = s.imask;
      default: rd_err = 1'b1;
    endcase
  end

  always_comb begin
    next_s = s;
    wr_err = 1'b0;
    wval = 32'h0;
    next_s.start_q = start_req;
    // Millisecond time base
    next_s.tick = 1'b0;
    if (s.tick_cnt >= TICK_LAST) begin
      next_s.tick_cnt = 16'h0;
      next_s.tick = 1'b1;
    end else begin
      next_s.tick_cnt = s.tick_cnt + 16'h1;
    end
    // Register writes
    if (wr_en) begin
      case (wr_addr)
        ADDR_CTRL: begin
          wval = (32'(s.ctrl) & ~wmask) | (wr_data & wmask);
          next_s.ctrl = wval[4:0];
        end
        ADDR_AMP: begin
          wval = (32'(s.amp_reg) & ~wmask) | (wr_data & wmask);
          next_s.amp_reg = wval[6:0];
        end
        ADDR_TIME: begin
          wval = (32'(s.time_reg) & ~wmask) | (wr_data & wmask);
          next_s.time_reg = wval[23:0];
        end
        ADDR_OFFS: begin
          wval = (32'(s.offs_reg) & ~wmask) | (wr_data & wmask);
          next_s.offs_reg = wval[7:0];
        end
        ADDR_ISTAT: begin
          wval = wr_data & wmask;
          next_s.istat = s.istat & ~wval[2:0];
        end
        ADDR_IMASK: begin
          wval = (32'(s.imask) & ~wmask) | (wr_data & wmask);
          next_s.imask = wval[2:0];
        end
        ADDR_STAT, ADDR_FREQ: wr_err = 1'b0;
        default: wr_err = 1'b1;
      endcase
    end
    // Alarm clear, then set wins
    if (s.ctrl[CTRL_LATCH] && (panel_reset || ext_reset_req)) begin
      next_s.alarm = 1'b0;
      next_s.ovl = 1'b0;
    end
    if (!s.ctrl[CTRL_LATCH] && start_rise) begin
      next_s.alarm = 1'b0;
      next_s.ovl = 1'b0;
    end
    if (fault) begin
      next_s.alarm = 1'b1;
      next_s.istat[IRQ_ALARM] = 1'b1;
    end
    if (overload_in) begin
      next_s.ovl = 1'b1;
    end
    // Seek interval counts from the last start out of idle, into ramp or seek
    if (s.tick && s.ivl_cnt < SEEK_LAST) begin
      next_s.ivl_cnt = s.ivl_cnt + 16'h1;
    end
    // Ramp step of one percent per ramp_sel ms
    if (s.tick) begin
      next_s.step_cnt = s.step_cnt + 8'h1;
    end
    if ((s.st == WCS_RAMP || s.st == WCS_SEEK) && s.amp < amp_tgt &&
        (ramp_sel == 8'h0 || (s.tick && s.step_cnt + 8'h1 >= ramp_sel)))
        begin
      next_s.amp = s.amp + 7'h1;
      next_s.step_cnt = 8'h0;
    end
    case (s.st)
      WCS_IDLE: begin
        next_s.amp = 7'h0;
        if (may_start) begin
          next_s.st = WCS_RAMP;
          next_s.offs = offs_sel;
          next_s.step_cnt = 8'h0;
          next_s.ivl_cnt = 16'h0;
        end else if (s.ctrl[CTRL_TSEEK] && s.ivl_cnt >= SEEK_LAST &&
            s.tick && !s.alarm && !fault) begin
          next_s.st = WCS_SEEK;
          next_s.offs = offs_sel;
          next_s.step_cnt = 8'h0;
          next_s.seek_ms = 8'h0;
          next_s.ivl_cnt = 16'h0;
        end
      end
      WCS_RAMP, WCS_WELD: begin
        if (s.st == WCS_RAMP && s.amp >= amp_tgt) begin
          next_s.st = WCS_WELD;
        end
        if (s.st == WCS_WELD) begin
          next_s.amp = amp_tgt;
        end
        if (fault) begin
          next_s.st = WCS_IDLE;
          next_s.amp = 7'h0;
        end else if (!start_req) begin
          next_s.st = WCS_IDLE;
          next_s.amp = 7'h0;
          next_s.istat[IRQ_DONE] = 1'b1;
          if (s.ctrl[CTRL_EOW]) begin
            next_s.freq = meas_freq;
          end
        end
      end
      WCS_SEEK: begin
        if (s.tick) begin
          next_s.seek_ms = s.seek_ms + 8'h1;
        end
        if (fault) begin
          next_s.st = WCS_IDLE;
          next_s.amp = 7'h0;
        end else if (may_start) begin
          next_s.st = WCS_RAMP;
          next_s.amp = 7'h0;
          next_s.offs = offs_sel;
          next_s.step_cnt = 8'h0;
        end else if (s.tick && s.seek_ms + 8'h1 >=
            s.time_reg[TM_KTIME +: 8]) begin
          next_s.st = WCS_IDLE;
          next_s.amp = 7'h0;
          next_s.freq = meas_freq;
          next_s.istat[IRQ_SEEK] = 1'b1;
        end
      end
      default: next_s.st = WCS_IDLE;
    endcase
    // Registered status outputs
    next_s.sonics = next_s.st == WCS_RAMP || next_s.st == WCS_WELD;
    next_s.seek = next_s.st == WCS_SEEK;
    next_s.rdy = next_s.st == WCS_IDLE && !next_s.alarm;
    next_s.irq = |(next_s.istat & next_s.imask);
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s <= '0;
      s.ctrl <= CTRL_RST;
      s.amp_reg <= AMP_RST;
      s.time_reg <= TIME_RST;
      s.offs_reg <= OFFS_RST;
    end else begin
      s <= next_s;
    end
  end

  assign sonics_on = s.sonics;
  assign seek_active = s.seek;
  assign sys_ready = s.rdy;
  assign gen_alarm = s.alarm;
  assign ovl_alarm = s.ovl;
  assign amp_out = s.amp;
  assign freq_offset = s.offs;
  assign irq = s.irq;

  AST_START: assert property (@(posedge ref_clk) disable iff (srst)
    s.st == WCS_IDLE && start_rise && !fault && !s.ctrl[CTRL_LATCH]
    |=> sonics_on) else $error("start did not raise sonics");
  AST_HOLD: assert property (@(posedge ref_clk) disable iff (srst)
    sonics_on && start_req && !fault |=> sonics_on)
    else $error("sonics dropped while start held");
  AST_STOP: assert property (@(posedge ref_clk) disable iff (srst)
    sonics_on && !start_req |=> !sonics_on && amp_out == 7'h0)
    else $error("sonics stayed on after start released");
  AST_REFUSE: assert property (@(posedge ref_clk) disable iff (srst)
    !sonics_on && start_rise && s.ctrl[CTRL_LATCH] && gen_alarm
    |=> !sonics_on) else $error("start taken while latched");
  AST_CLEAR: assert property (@(posedge ref_clk) disable iff (srst)
    s.ctrl[CTRL_LATCH] && gen_alarm && (ext_reset_req || panel_reset)
    && !fault |=> !gen_alarm) else $error("reset left alarm");
  AST_NLCLR: assert property (@(posedge ref_clk) disable iff (srst)
    !s.ctrl[CTRL_LATCH] && gen_alarm && start_rise && !fault &&
    s.st == WCS_IDLE |=> !gen_alarm ##0 sonics_on)
    else $error("start did not clear alarm");
  AST_DEFMODE: assert property (@(posedge ref_clk)
    $past(srst) |-> !s.ctrl[CTRL_LATCH])
    else $error("alarm mode not non-latching");
  AST_AMPLIM: assert property (@(posedge ref_clk) disable iff (srst)
    amp_out <= AMP_MAX) else $error("amplitude over limit");
  AST_RAMP0: assert property (@(posedge ref_clk) disable iff (srst)
    $rose(sonics_on) |-> amp_out == 7'h0 ##1 amp_out <= 7'h1)
    else $error("ramp did not start from zero");
  AST_EOW: assert property (@(posedge ref_clk) disable iff (srst)
    sonics_on && !start_req && !fault && s.ctrl[CTRL_EOW]
    |=> s.freq == $past(meas_freq))
    else $error("end of weld frequency not stored");
  AST_FALLBK: assert property (@(posedge ref_clk) disable iff (srst)
    s.st == WCS_WELD && s.ctrl[CTRL_AMPEXT] && !ext_amp_ok
    |=> s.st != WCS_WELD || amp_out == AMP_FALLBACK)
    else $error("no fallback amplitude");
  AST_ALARM: assert property (@(posedge ref_clk) disable iff (srst)
    sonics_on && fault |=> !sonics_on && gen_alarm)
    else $error("alarm did not stop sonics");
endmodule
`default_nettype wire

// ---- verilog/wcs_pkg.sv ----
// Shared constants and types of the weld cycle alarm sequencer.
// Assumes one 40 MHz clock and a 32-bit AXI4-Lite register bus.
package wcs_pkg;
  // Clock and time base
  localparam int CLK_NS = 25;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int SEEK_IVL_S = 60;
  localparam int SEEK_IVL_MS = SEEK_IVL_S * 1000;
  // Amplitude and offset limits
  localparam logic [6:0] AMP_MIN = 7'h0a;
  localparam logic [6:0] AMP_MAX = 7'h64;
  localparam logic [6:0] AMP_FALLBACK = 7'h32;
  localparam logic [7:0] OFFS_ZERO = 8'h00;
  // Register byte addresses
  localparam int AXI_AW = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_AMP = 8'h04;
  localparam logic [7:0] ADDR_TIME = 8'h08;
  localparam logic [7:0] ADDR_OFFS = 8'h0c;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [7:0] ADDR_FREQ = 8'h14;
  localparam logic [7:0] ADDR_ISTAT = 8'h18;
  localparam logic [7:0] ADDR_IMASK = 8'h1c;
  // Control bits
  localparam int CTRL_LATCH = 0;
  localparam int CTRL_EOW = 1;
  localparam int CTRL_TSEEK = 2;
  localparam int CTRL_AMPEXT = 3;
  localparam int CTRL_OFFEXT = 4;
  // Timing register fields, 8 bits each, in ms
  localparam int TM_SRAMP = 0;
  localparam int TM_KRAMP = 8;
  localparam int TM_KTIME = 16;
  // Interrupt bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ALARM = 1;
  localparam int IRQ_SEEK = 2;
  // Reset values
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [6:0] AMP_RST = 7'h32;
  localparam logic [23:0] TIME_RST = 24'h0a0a0a;
  localparam logic [7:0] OFFS_RST = 8'h00;
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {WCS_IDLE, WCS_RAMP, WCS_WELD, WCS_SEEK}
    wcs_state_t;
endpackage

// ---- verilog/wcs_axil.sv ----
// AXI4-Lite slave front end of the sequencer register file.
// Assumes the owner decodes the address and answers within a cycle.
`timescale 1ns/1ps
`default_nettype none
module wcs_axil (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Write address and data
  input wire logic [wcs_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address and data
  input wire logic [wcs_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Register file side
  output logic wr_en,
  output logic [wcs_pkg::AXI_AW-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_err,
  output logic [wcs_pkg::AXI_AW-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);
  import wcs_pkg::*;
  typedef struct packed {
    logic aw_full;
    logic [AXI_AW-1:0] awaddr;
    logic aw_rdy;
    logic w_full;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic w_rdy;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_busy;
    logic [AXI_AW-1:0] araddr;
    logic ar_rdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } wcs_axil_st_t;
  wcs_axil_st_t s;
  wcs_axil_st_t next_s;
  logic wr_go;
  assign wr_go = s.aw_full && s.w_full && !s.bvalid;
  always_comb begin
    next_s = s;
    if (s.aw_rdy && s_axi_awvalid) begin
      next_s.aw_full = 1'b1;
      next_s.awaddr = s_axi_awaddr;
    end
    if (s.w_rdy && s_axi_wvalid) begin
      next_s.w_full = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end
    if (wr_go) begin
      next_s.aw_full = 1'b0;
      next_s.w_full = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = wr_err ? RESP_SLVERR : RESP_OKAY;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.ar_rdy && s_axi_arvalid) begin
      next_s.ar_busy = 1'b1;
      next_s.araddr = s_axi_araddr;
    end
    if (s.ar_busy && !s.rvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = rd_data;
      next_s.rresp = rd_err ? RESP_SLVERR : RESP_OKAY;
    end
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
      next_s.ar_busy = 1'b0;
    end
    next_s.aw_rdy = !next_s.aw_full;
    next_s.w_rdy = !next_s.w_full;
    next_s.ar_rdy = !next_s.ar_busy;
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign s_axi_awready = s.aw_rdy;
  assign s_axi_wready = s.w_rdy;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.ar_rdy;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign wr_en = wr_go;
  assign wr_addr = s.awaddr;
  assign wr_data = s.wdata;
  assign wr_strb = s.wstrb;
  assign rd_addr = s.araddr;
endmodule
`default_nettype wire

// ---- sim/wcs_ctl_model.sv ----
// Automation controller model on the user I/O side of the sequencer.
// Assumes bench commands that change just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module wcs_ctl_model #(
  parameter int LAG = 1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Bench commands
  input wire logic weld_cmd,
  input wire logic clr_cmd,
  // User I/O toward the sequencer
  output logic start_req,
  output logic ext_reset_req
);
  logic [LAG-1:0] dly;
  // Start follows the command after LAG cycles, low between cycles
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dly <= '0;
      ext_reset_req <= 1'b0;
    end else begin
      dly <= LAG'({dly, weld_cmd});
      ext_reset_req <= clr_cmd;
    end
  end
  assign start_req = dly[LAG-1];
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench of the weld cycle and alarm sequencer.
// Assumes wcs_top and wcs_pkg compiled before it.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import wcs_pkg::*;
  typedef struct packed {
    logic [4:0] c; logic [6:0] ea; logic ao; logic [7:0] eo; logic oo;
    logic [15:0] mf; logic [6:0] xa; logic [7:0] xo; logic [15:0] xf;
  } wcs_row_t;
  logic ref_clk, srst, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0] awaddr, araddr, ext_offs, freq_offset;
  logic [31:0] wdata, rdata, q;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic weld_cmd, clr_cmd, start_req, ext_reset_req, panel_reset;
  logic alarm_in, overload_in, ext_amp_ok, ext_offs_ok;
  logic sonics_on, seek_active, sys_ready, gen_alarm, ovl_alarm;
  logic [6:0] ext_amp, amp_out, amax;
  logic [15:0] meas_freq;
  int err_total, checked, n;
  wcs_row_t rows [5] = '{
    '{5'h02, 7'h00, 1'b0, 8'h00, 1'b0, 16'h1234, 7'h40, 8'h10, 16'h1234},
    '{5'h08, 7'h50, 1'b1, 8'h00, 1'b0, 16'h5678, 7'h50, 8'h10, 16'h1234},
    '{5'h1a, 7'h05, 1'b1, 8'h20, 1'b1, 16'h9abc, 7'h32, 8'h20, 16'h9abc},
    '{5'h18, 7'h64, 1'b0, 8'hf0, 1'b0, 16'h1111, 7'h32, 8'h00, 16'h9abc},
    '{5'h0a, 7'h64, 1'b1, 8'h00, 1'b0, 16'h2222, 7'h64, 8'h10, 16'h2222}};

  wcs_top #(.TICK_CYCLES(4), .SEEK_MS(5)) u_dut (
    .ref_clk(ref_clk), .srst(srst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .start_req(start_req),
    .ext_reset_req(ext_reset_req), .panel_reset(panel_reset),
    .alarm_in(alarm_in), .overload_in(overload_in), .ext_amp(ext_amp),
    .ext_amp_ok(ext_amp_ok), .ext_offs(ext_offs),
    .ext_offs_ok(ext_offs_ok), .meas_freq(meas_freq),
    .sonics_on(sonics_on), .seek_active(seek_active),
    .sys_ready(sys_ready), .gen_alarm(gen_alarm), .ovl_alarm(ovl_alarm),
    .amp_out(amp_out), .freq_offset(freq_offset), .irq(irq));
  wcs_ctl_model #(.LAG(1)) u_ctl (
    .ref_clk(ref_clk), .srst(srst), .weld_cmd(weld_cmd),
    .clr_cmd(clr_cmd), .start_req(start_req),
    .ext_reset_req(ext_reset_req));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tmo(input int cnt, input int lim);
    if (cnt >= lim) begin
      err_total++;
      $display("wait limit reached at %0t", $time);
      summarize();
    end
  endtask

  // One AXI4-Lite write or read, waits for the response
  task automatic xfer(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    araddr <= a;
    awvalid <= wr;
    wvalid <= wr;
    bready <= wr;
    arvalid <= !wr;
    rready <= !wr;
    do begin
      @(posedge ref_clk);
      k++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (arready) arvalid <= 1'b0;
    end while (!(bvalid || rvalid) && k < 100);
    bready <= 1'b0;
    rready <= 1'b0;
    q = rdata;
    r = wr ? bresp : rresp;
    tmo(k, 100);
  endtask

  task automatic wait_sonics(input logic lvl);
    for (n = 0; n < 40 && sonics_on !== lvl; n++) @(negedge ref_clk);
    tmo(n, 40);
  endtask

  task automatic weld(input logic [6:0] xa, input logic [7:0] xo);
    @(posedge ref_clk);
    weld_cmd <= 1'b1;
    wait_sonics(1'b1);
    chk(amp_out, 32'h0);
    chk(freq_offset, xo);
    for (n = 0; n < 200 && amp_out !== xa; n++) @(negedge ref_clk);
    chk(amp_out, xa);
    repeat (8) @(negedge ref_clk);
    chk({sonics_on, amp_out}, {1'b1, xa});
    @(posedge ref_clk);
    weld_cmd <= 1'b0;
    wait_sonics(1'b0);
    chk({sonics_on, sys_ready, amp_out}, 32'h80);
  endtask

  task automatic pulse(input int which);
    @(posedge ref_clk);
    {panel_reset, clr_cmd, overload_in, alarm_in} <= 4'h1 << which;
    @(posedge ref_clk);
    {panel_reset, clr_cmd, overload_in, alarm_in} <= 4'h0;
    repeat (4) @(negedge ref_clk);
  endtask

  initial begin
    {srst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    {weld_cmd, clr_cmd, panel_reset, alarm_in, overload_in} = 5'h0;
    {ext_amp, ext_amp_ok, ext_offs, ext_offs_ok} = 17'h0;
    {awaddr, araddr, wdata, meas_freq} = 64'h0;
    wstrb = 4'hf;
    err_total = 0;
    checked = 0;
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    xfer(1'b1, ADDR_AMP, 32'h40);
    xfer(1'b1, ADDR_OFFS, 32'h10);
    xfer(1'b1, ADDR_TIME, 32'h020100);
    xfer(1'b1, ADDR_IMASK, 32'h1);
    foreach (rows[i]) begin
      xfer(1'b1, ADDR_CTRL, {27'h0, rows[i].c});
      @(posedge ref_clk);
      {ext_amp, ext_amp_ok} <= {rows[i].ea, rows[i].ao};
      {ext_offs, ext_offs_ok} <= {rows[i].eo, rows[i].oo};
      meas_freq <= rows[i].mf;
      weld(rows[i].xa, rows[i].xo);
      xfer(1'b0, ADDR_FREQ, 32'h0);
      chk(q, {16'h0, rows[i].xf});
    end
    // Done interrupt: pending, masked, unmasked, cleared
    chk(irq, 32'h1);
    xfer(1'b1, ADDR_IMASK, 32'h0);
    repeat (2) @(negedge ref_clk);
    chk(irq, 32'h0);
    xfer(1'b1, ADDR_IMASK, 32'h3);
    repeat (2) @(negedge ref_clk);
    chk(irq, 32'h1);
    xfer(1'b1, ADDR_ISTAT, 32'h1);
    repeat (2) @(negedge ref_clk);
    chk(irq, 32'h0);
    // Latching alarms
    xfer(1'b1, ADDR_CTRL, 32'h1);
    @(posedge ref_clk);
    weld_cmd <= 1'b1;
    wait_sonics(1'b1);
    pulse(0);
    chk({sonics_on, gen_alarm, irq}, 32'h3);
    @(posedge ref_clk);
    weld_cmd <= 1'b0;
    repeat (3) @(posedge ref_clk);
    weld_cmd <= 1'b1;
    repeat (8) @(negedge ref_clk);
    chk({sonics_on, gen_alarm}, 32'h1);
    @(posedge ref_clk);
    weld_cmd <= 1'b0;
    pulse(2);
    chk({gen_alarm, sys_ready}, 32'h1);
    pulse(1);
    chk({ovl_alarm, gen_alarm, sys_ready}, 32'h6);
    pulse(3);
    chk({ovl_alarm, gen_alarm, sys_ready}, 32'h1);
    // Non-latching: a new start clears the alarm
    xfer(1'b1, ADDR_CTRL, 32'h0);
    pulse(0);
    chk(gen_alarm, 32'h1);
    weld(7'h40, 8'h10);
    chk(gen_alarm, 32'h0);
    // Register amplitude below range is raised to the lower limit
    xfer(1'b1, ADDR_AMP, 32'h05);
    weld(7'h0a, 8'h10);
    // Timed seek
    meas_freq <= 16'h4321;
    xfer(1'b1, ADDR_CTRL, 32'h4);
    for (n = 0; n < 400 && seek_active !== 1'b1; n++) @(negedge ref_clk);
    tmo(n, 400);
    amax = 7'h0;
    for (n = 0; n < 100 && seek_active === 1'b1; n++) begin
      if (amp_out > amax) amax = amp_out;
      @(negedge ref_clk);
    end
    chk(n >= 4 && n <= 12, 32'h1);
    chk(amax >= 7'h1 && amax <= 7'h2, 32'h1);
    xfer(1'b1, ADDR_CTRL, 32'h0);
    xfer(1'b0, ADDR_FREQ, 32'h0);
    chk(q, 32'h4321);
    // Second reset and reset values
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    chk({sonics_on, gen_alarm, irq}, 32'h0);
    xfer(1'b0, ADDR_CTRL, 32'h0);
    chk(q, 32'h0);
    xfer(1'b0, ADDR_AMP, 32'h0);
    chk(q, 32'h32);
    xfer(1'b0, ADDR_TIME, 32'h0);
    chk(q, 32'h0a0a0a);
    xfer(1'b0, 8'h20, 32'h0);
    chk(q, 32'h0);
    chk(r, RESP_SLVERR);
    xfer(1'b1, 8'h24, 32'h1);
    chk(r, RESP_SLVERR);
    summarize();
  end
endmodule
`default_nettype wire
